// ==== logic/madc_pkg.sv ====
package madc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] MADC_ADDR_SETUP     = 8'h2E;
	localparam logic [7:0] MADC_ADDR_DISABLE_A = 8'h2F;
	localparam logic [7:0] MADC_ADDR_DISABLE_B = 8'h30;

	localparam logic [7:0] MADC_SETUP_RESET     = 8'h30;
	localparam logic [7:0] MADC_DISABLE_A_RESET = 8'h00;
	localparam logic [7:0] MADC_DISABLE_B_RESET = 8'h00;

	// Writable bit masks; everything else reads as zero.
	localparam logic [7:0] MADC_SETUP_MASK     = 8'hFC;
	localparam logic [7:0] MADC_DISABLE_A_MASK = 8'hFE;
	localparam logic [7:0] MADC_DISABLE_B_MASK = 8'hF0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int MADC_RUN_BIT       = 7;
	localparam int MADC_RATE_BIT      = 6;
	localparam int MADC_SPEED_HI      = 5;
	localparam int MADC_SPEED_LO      = 4;
	localparam int MADC_AVG_BIT       = 3;
	localparam int MADC_SEED_BIT      = 2;
	localparam int MADC_IBUS_OFF_BIT  = 7;
	localparam int MADC_IBAT_OFF_BIT  = 6;
	localparam int MADC_VBUS_OFF_BIT  = 5;
	localparam int MADC_VBAT_OFF_BIT  = 4;
	localparam int MADC_VSYS_OFF_BIT  = 3;
	localparam int MADC_THERM_OFF_BIT = 2;
	localparam int MADC_DIE_OFF_BIT   = 1;
	localparam int MADC_DP_OFF_BIT    = 7;
	localparam int MADC_DM_OFF_BIT    = 6;
	localparam int MADC_IN2_OFF_BIT   = 5;
	localparam int MADC_IN1_OFF_BIT   = 4;

	localparam int MADC_NUM_CH = 11;

	typedef enum logic [0:0] {
		MADC_CONTINUOUS = 1'b0,
		MADC_ONE_SHOT   = 1'b1
	} madc_rate_t;

endpackage

// ==== logic/madc_ctrl.sv ====
// Notes on behaviour
// [R1] Setup bit 7 enables conversions and is cleared by register reset and by watchdog expiry.
// [R2] Setup bit 6 picks continuous (0) or one-shot (1) conversion and is cleared only by register reset.
// [R3] Setup bits 5-4 pick 15, 14, 13 or 12 bit effective resolution and reset to 3.
// [R4] Setup bit 3 picks single values (0) or a running average (1), resetting to 0.
// [R5] Setup bit 2 seeds the average from the old result (0) or a fresh conversion (1), resetting to 0.
// [R6] Disable register A bits 7 and 6 switch off bus and battery current channels, resetting to 0.
// [R7] Disable register A bits 5, 4 and 3 switch off bus, battery and system voltage channels.
// [R8] Disable register A bits 2 and 1 switch off thermistor and die temperature channels, resetting to 0.
// [R9] Disable register B bits 7 and 6 switch off the D+ and D- channels, resetting to 0.
// [R10] Disable register B bits 5 and 4 switch off the two input-sense channels, resetting to 0.
// [R11] Channels switched off are skipped by the sequencer in both modes and keep their last result.
// [R12] Reserved bits read as zero and ignore writes.
// [R13] Conversion done pulses an interrupt only in one-shot mode and only while its mask bit is 0.
// [R14] The bus current result is a signed 16-bit value, positive for current into the device.
`timescale 1ns/10ps
`default_nettype none

module madc_ctrl
	import madc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        reg_reset,
	input  wire logic        watchdog_expired,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        conv_done_mask,
	input  wire logic        conv_done,
	input  wire logic        conv_ready,
	input  wire logic [15:0] conv_result,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	output logic             conv_start,
	output logic      [3:0]  conv_channel,
	output logic      [1:0]  sample_speed,
	output logic             averaging_select,
	output logic             average_seed_select,
	output logic             seq_busy,
	output logic             conv_done_irq,
	output logic signed [15:0] bus_current_result
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		MADC_IDLE = 2'b00,
		MADC_PICK = 2'b01,
		MADC_WAIT = 2'b10
	} madc_seq_t;

	typedef struct packed {
		logic [7:0]  setup;
		logic [7:0]  dis_a;
		logic [7:0]  dis_b;
		logic [7:0]  rdata;
		logic        rvalid;
		madc_seq_t   seq;
		logic [3:0]  ch;
		logic        fresh;
		logic        busy;
		logic        start;
		logic        pass_done;
		logic        irq;
		logic [15:0] ibus;
	} madc_state_t;

	madc_state_t st_r;
	madc_state_t st_nxt;

	logic [MADC_NUM_CH-1:0] ch_off;
	logic [3:0]             next_ch;
	logic                   have_next;

	// ****************************************
	// Channel scan
	// ****************************************

	// Channel order: ibus, ibat, vbus, vbat, vsys, therm, die, dp, dm, in2, in1.
	always_comb begin
		ch_off = {st_r.dis_b[MADC_IN1_OFF_BIT], st_r.dis_b[MADC_IN2_OFF_BIT],
		          st_r.dis_b[MADC_DM_OFF_BIT], st_r.dis_b[MADC_DP_OFF_BIT],
		          st_r.dis_a[MADC_DIE_OFF_BIT], st_r.dis_a[MADC_THERM_OFF_BIT],
		          st_r.dis_a[MADC_VSYS_OFF_BIT], st_r.dis_a[MADC_VBAT_OFF_BIT],
		          st_r.dis_a[MADC_VBUS_OFF_BIT], st_r.dis_a[MADC_IBAT_OFF_BIT],
		          st_r.dis_a[MADC_IBUS_OFF_BIT]}; // [R6] [R7] [R8] [R9] [R10]
	end

	// A fresh pass scans from channel 0, otherwise the scan resumes just above the last channel.
	// The channel register keeps the previous pass's last channel, so it cannot seed a new pass.
	always_comb begin
		logic [3:0] base;
		base      = st_r.fresh ? 4'h0 : 4'(st_r.ch + 4'h1);
		next_ch   = 4'h0;
		have_next = 1'b0;
		for (int i = MADC_NUM_CH - 1; i >= 0; i--) begin
			if (4'(i) >= base && !ch_off[i]) begin // [R11]
				next_ch   = 4'(i);
				have_next = 1'b1;
			end
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt        = st_r;
		st_nxt.start  = 1'b0;
		st_nxt.irq    = 1'b0;
		st_nxt.rvalid = reg_rd;
		st_nxt.rdata  = 8'h00;

		// ****************************************
		// Register access
		// ****************************************
		if (reg_rd) begin
			case (reg_addr)
				MADC_ADDR_SETUP:     st_nxt.rdata = st_r.setup & MADC_SETUP_MASK; // [R12]
				MADC_ADDR_DISABLE_A: st_nxt.rdata = st_r.dis_a & MADC_DISABLE_A_MASK; // [R12]
				MADC_ADDR_DISABLE_B: st_nxt.rdata = st_r.dis_b & MADC_DISABLE_B_MASK; // [R12]
				default:             st_nxt.rdata = 8'h00;
			endcase
		end

		if (reg_wr) begin
			case (reg_addr)
				MADC_ADDR_SETUP: begin
					st_nxt.setup     = reg_wdata & MADC_SETUP_MASK; // [R1] [R2] [R3] [R4] [R5] [R12]
					st_nxt.pass_done = 1'b0;
				end
				MADC_ADDR_DISABLE_A: st_nxt.dis_a = reg_wdata & MADC_DISABLE_A_MASK; // [R6] [R7] [R8] [R12]
				MADC_ADDR_DISABLE_B: st_nxt.dis_b = reg_wdata & MADC_DISABLE_B_MASK; // [R9] [R10] [R12]
				default: ;
			endcase
		end

		// ****************************************
		// Sequencer
		// ****************************************
		// One pass over enabled channels, repeated only in continuous mode.
		case (st_r.seq)
			MADC_IDLE: begin
				if (st_r.setup[MADC_RUN_BIT] && !st_r.pass_done) begin
					st_nxt.seq   = MADC_PICK;
					st_nxt.fresh = 1'b1;
				end
			end
			MADC_PICK: begin
				if (!st_r.setup[MADC_RUN_BIT]) begin
					st_nxt.seq = MADC_IDLE;
				end else if (!have_next) begin
					st_nxt.seq = MADC_IDLE;
					// A one-shot pass drops the run bit itself, so software can see that it ended.
					if (st_r.setup[MADC_RATE_BIT] == MADC_ONE_SHOT) begin
						st_nxt.pass_done = 1'b1;
						st_nxt.irq       = !conv_done_mask; // [R13]
						st_nxt.setup[MADC_RUN_BIT] = 1'b0;
					end
				end else if (conv_ready) begin
					st_nxt.ch    = next_ch; // [R11]
					st_nxt.fresh = 1'b0;
					st_nxt.start = 1'b1;
					st_nxt.seq   = MADC_WAIT;
				end
			end
			MADC_WAIT: begin
				if (conv_done) begin
					if (st_r.ch == 4'h0) begin
						st_nxt.ibus = conv_result; // [R14]
					end
					st_nxt.seq = MADC_PICK;
				end
			end
			default: st_nxt.seq = MADC_IDLE;
		endcase

		// ****************************************
		// Overrides
		// ****************************************
		// Register reset comes last, so it beats the watchdog and any write in the same cycle.
		if (watchdog_expired) begin
			st_nxt.setup[MADC_RUN_BIT] = 1'b0; // [R1]
		end
		if (reg_reset) begin
			st_nxt.setup     = MADC_SETUP_RESET; // [R1] [R2] [R3] [R4] [R5]
			st_nxt.dis_a     = MADC_DISABLE_A_RESET;
			st_nxt.dis_b     = MADC_DISABLE_B_RESET;
			st_nxt.seq       = MADC_IDLE;
			st_nxt.pass_done = 1'b0;
		end

		// Busy is kept as its own flop so that the port comes straight from a register.
		st_nxt.busy = (st_nxt.seq != MADC_IDLE);
	end

	// ****************************************
	// State register
	// ****************************************

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r       <= '0;
			st_r.setup <= MADC_SETUP_RESET;
			st_r.seq   <= MADC_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	assign reg_rdata           = st_r.rdata;
	assign reg_rvalid          = st_r.rvalid;
	assign conv_start          = st_r.start;
	assign conv_channel        = st_r.ch;
	assign sample_speed        = st_r.setup[MADC_SPEED_HI:MADC_SPEED_LO]; // [R3]
	assign averaging_select    = st_r.setup[MADC_AVG_BIT]; // [R4]
	assign average_seed_select = st_r.setup[MADC_SEED_BIT]; // [R5]
	assign seq_busy            = st_r.busy;
	assign conv_done_irq       = st_r.irq;
	assign bus_current_result  = st_r.ibus;

endmodule

`default_nettype wire

// ==== test/madc_ctrl_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// *****
// Checker
// *****
module madc_ctrl_sva
	import madc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reg_reset,
	input wire logic       watchdog_expired,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       conv_done_mask,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] sample_speed,
	input wire logic       averaging_select,
	input wire logic       average_seed_select,
	input wire logic       conv_done_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire ws = reg_wr && !reg_reset && reg_addr == MADC_ADDR_SETUP;
	wire rs = reg_rd && reg_addr == MADC_ADDR_SETUP;
	chk_speed_wr: assert property (ws |=> sample_speed == $past(reg_wdata[5:4]))
		else $error("speed field not written");
	chk_avg_seed_wr: assert property (ws |=> {averaging_select, average_seed_select} == $past(reg_wdata[3:2]))
		else $error("averaging fields not written");
	chk_reset_vals: assert property (reg_reset |=> sample_speed == 2'h3 && !averaging_select && !average_seed_select)
		else $error("register reset values wrong");
	chk_rsvd_setup: assert property (rs |=> reg_rdata[1:0] == 2'h0)
		else $error("setup reserved bits not zero");
	chk_rsvd_a: assert property (reg_rd && reg_addr == MADC_ADDR_DISABLE_A |=> !reg_rdata[0])
		else $error("disable a reserved bit not zero");
	chk_rsvd_b: assert property (reg_rd && reg_addr == MADC_ADDR_DISABLE_B |=> reg_rdata[3:0] == 4'h0)
		else $error("disable b reserved bits not zero");
	chk_wd_run: assert property (watchdog_expired ##1 rs |=> !reg_rdata[7])
		else $error("run bit survived watchdog");
	chk_irq_mask: assert property (conv_done_irq |-> !$past(conv_done_mask))
		else $error("done pulse while masked");
endmodule
bind madc_ctrl madc_ctrl_sva i_madc_ctrl_sva (.clk, .rst, .reg_reset, .watchdog_expired, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .conv_done_mask, .reg_rdata, .sample_speed, .averaging_select, .average_seed_select,
	.conv_done_irq);
`default_nettype wire

// ==== test/madc_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// *****
// Converter core model
// *****
module madc_core_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        conv_start,
	input  wire logic [3:0]  conv_channel,
	output logic             conv_done,
	output logic             conv_ready,
	output logic      [15:0] conv_result
);
	logic [2:0] cnt_r;
	logic [3:0] ch_r;
	always_ff @(posedge clk) begin
		conv_done <= !rst && cnt_r == 3'h1;
		if (rst) begin
			cnt_r <= 3'h0;
			ch_r <= 4'h0;
		end else if (conv_start) begin
			cnt_r <= 3'h4;
			ch_r <= conv_channel;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
	assign conv_ready = cnt_r == 3'h0 && !conv_done;
	// Outside the done cycle the bus carries the inverse, so a late sample cannot pass.
	assign conv_result = conv_done ? {12'hFFF, ch_r} : ~{12'hFFF, ch_r};
endmodule
`default_nettype wire

// ==== test/madc_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module madc_ctrl_tb
	import madc_pkg::*;
;
	logic clk = 0, rst = 1, reg_reset = 0, watchdog_expired = 0, reg_wr = 0, reg_rd = 0, conv_done_mask = 0;
	logic conv_done, conv_ready, conv_start, reg_rvalid, seq_busy, conv_done_irq, averaging_select;
	logic average_seed_select;
	logic [1:0] sample_speed;
	logic [3:0] conv_channel;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [15:0] conv_result;
	logic signed [15:0] bus_current_result;
	int err_count, checked, cyc, irqs, busy_cycles;
	logic [3:0] chq[$];
	madc_ctrl i_madc_ctrl (.clk, .rst, .reg_reset, .watchdog_expired, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.conv_done_mask, .conv_done, .conv_ready, .conv_result, .reg_rdata, .reg_rvalid, .conv_start, .conv_channel,
		.sample_speed, .averaging_select, .average_seed_select, .seq_busy, .conv_done_irq, .bus_current_result);
	madc_core_model i_madc_core_model (.clk, .rst, .conv_start, .conv_channel, .conv_done, .conv_ready, .conv_result);
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", {15'h0, reg_rvalid}, 16'h1);
		chk("rdata", {8'h0, reg_rdata}, {8'h0, e});
	endtask
	task automatic pass(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s, input int n);
		wr(MADC_ADDR_DISABLE_A, a);
		wr(MADC_ADDR_DISABLE_B, b);
		chq.delete();
		irqs = 0;
		busy_cycles = 0;
		wr(MADC_ADDR_SETUP, s);
		repeat (n) @(posedge clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Pulses are tallied on the falling edge, where the design's flops have long settled.
	always @(negedge clk) begin
		cyc++;
		if (conv_start === 1'b1) chq.push_back(conv_channel);
		if (conv_done_irq === 1'b1) irqs++;
		if (seq_busy === 1'b1) busy_cycles++;
		if (cyc == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(8'h2E, 8'h30);
		rd(8'h2F, 8'h00);
		rd(8'h30, 8'h00);
		wr(8'h2E, 8'h57);
		rd(8'h2E, 8'h54);
		chk("fields", {12'h0, sample_speed, averaging_select, average_seed_select}, 16'h5);
		wr(8'h2E, 8'h68);
		rd(8'h2E, 8'h68);
		chk("fields", {12'h0, sample_speed, averaging_select, average_seed_select}, 16'hA);
		wr(8'h2F, 8'hFF);
		rd(8'h2F, 8'hFE);
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'hF0);
		rd(8'h31, 8'h00);
		@(posedge clk) reg_reset <= 1'b1;
		@(posedge clk) reg_reset <= 1'b0;
		rd(8'h2E, 8'h30);
		rd(8'h2F, 8'h00);
		rd(8'h30, 8'h00);
		pass(8'hBE, 8'hB0, 8'hC0, 60);
		chk("starts", 16'(chq.size()), 16'h2);
		chk("first", {12'h0, chq[0]}, 16'h1);
		chk("second", {12'h0, chq[1]}, 16'h8);
		chk("irq", 16'(irqs), 16'h1);
		chk("busy seen", {15'h0, busy_cycles > 0}, 16'h1);
		chk("busy after", {15'h0, seq_busy}, 16'h0);
		rd(8'h2E, 8'h40);
		@(posedge clk) conv_done_mask <= 1'b1;
		pass(8'h7E, 8'hF0, 8'hC0, 40);
		chk("masked", {15'h0, chq.size() == 1 && chq[0] == 4'h0}, 16'h1);
		chk("irq", 16'(irqs), 16'h0);
		chk("ibus", bus_current_result, 16'hFFF0);
		pass(8'h7E, 8'hF0, 8'h80, 60);
		chk("repeat", {15'h0, chq.size() > 2}, 16'h1);
		watchdog_expired <= 1'b1;
		rd(8'h2E, 8'h00);
		@(posedge clk) watchdog_expired <= 1'b0;
		repeat (30) @(posedge clk);
		chq.delete();
		repeat (40) @(posedge clk);
		chk("stopped", 16'(chq.size()), 16'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
